// ==== core/rcw_chain.sv ====
`timescale 1ns/100ps

module rcw_chain (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic tick,
    input wire logic clr_all,
    input wire logic clr_pre,
    input wire logic clr_service,
    input wire logic rate_sel,
    // State
    output logic [rcw_pkg::PRE_W-1:0] pre_cnt,
    output logic [rcw_pkg::TMO_W-1:0] tmo_cnt,
    output logic ovf
);

    logic [rcw_pkg::PRE_W-1:0] pre_next;
    logic [rcw_pkg::TMO_W-1:0] tmo_next;
    logic ovf_next;
    wire logic carry = tick & (pre_cnt == rcw_pkg::PRE_TOP);
    wire logic at_top = rate_sel ? (tmo_cnt == rcw_pkg::TMO_SHORT)
                                 : (tmo_cnt == rcw_pkg::TMO_TOP);

    always_comb begin
        pre_next = pre_cnt;
        tmo_next = tmo_cnt;
        ovf_next = 1'b0;
        if (clr_all) begin
            pre_next = '0;
            tmo_next = '0;
        end else begin
            if (tick) begin
                pre_next = pre_cnt + 12'h001; // [R1]
            end
            if (carry) begin
                tmo_next = tmo_cnt + 6'h01; // [R19]
                ovf_next = at_top; // [R3]
            end
            if (clr_pre) begin
                pre_next = '0;
            end
            if (clr_service) begin
                // Low four stages keep running, hence the 2^4 short of a full period
                pre_next[rcw_pkg::PRE_W-1:rcw_pkg::SERVICE_LOW] = '0; // [R5]
                tmo_next = '0;
                ovf_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= '0;
            tmo_cnt <= '0;
            ovf <= 1'b0;
        end else begin
            pre_cnt <= pre_next;
            tmo_cnt <= tmo_next;
            ovf <= ovf_next;
        end
    end

endmodule // rcw_chain

// ==== core/rcw_pkg.sv ====
package rcw_pkg;

    // ****************************************
    // Register map (printed offsets are word indexes)
    // ****************************************
    localparam int ADDR_W = 18;
    localparam logic [15:0] CLEAR_IDX = 16'hffff;
    localparam logic [15:0] CONFIG_IDX = 16'hfffe;
    localparam logic [15:0] CAUSE_IDX = 16'hfe01;
    localparam logic [15:0] MASK_IDX = 16'hfe02;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int CFG_DIS_BIT = 0;
    localparam int CFG_STOP_EN_BIT = 1;
    localparam int CFG_RATE_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CAUSE_W = 2;
    localparam int CAUSE_WDG_BIT = 0;
    localparam int CAUSE_ILL_BIT = 1;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 2'h0;
    localparam logic [CAUSE_W-1:0] MASK_RESET = 2'h0;

    // ****************************************
    // Counter chain
    // ****************************************
    localparam int PRE_W = 12;
    localparam int TMO_W = 6;
    localparam int SERVICE_LOW = 4;
    localparam logic [PRE_W-1:0] PRE_TOP = 12'hfff;
    localparam logic [TMO_W-1:0] TMO_TOP = 6'h3f;
    localparam logic [TMO_W-1:0] TMO_SHORT = 6'h01;

    // ****************************************
    // Slow-clock counts
    // ****************************************
    localparam int HOLD_W = 5;
    localparam logic [HOLD_W-1:0] HOLD_LAST = 5'h1f;
    localparam logic [11:0] POR_LAST = 12'hfff;

    typedef enum logic [1:0] {
        RCW_RUN = 2'b01,
        RCW_HOLD = 2'b10
    } rcw_state_t;

endpackage

// ==== core/rcw_sync.sv ====
`timescale 1ns/100ps

module rcw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule // rcw_sync

// ==== core/rcw_watchdog.sv ====
`timescale 1ns/100ps

// Functional notes
// [R1] 6-bit timeout counter after 12-bit prescaler
// [R2] Chain runs from internal slow clock
// [R3] Rate bit picks short or long timeout
// [R4] Overflow without restart raises reset
// [R5] Clear-port write clears timeout, prescaler upper stages
// [R6] Clear-port read returns vector low byte
// [R7] Reset pin low 32 ticks, cause flag
// [R8] Prescaler cleared 4096 ticks after power-up
// [R9] Internal reset clears both counters
// [R10] Reset vector fetch clears prescaler
// [R11] Disable bit blocks watchdog resets
// [R12] No processor interrupt, only reset
// [R13] Monitor mode with test voltage disables
// [R14] Counting continues in wait mode
// [R15] Stop mode freezes count, clears prescaler
// [R16] Disabled stop instruction gives illegal-opcode reset
// [R17] Break with test voltage on reset pin disables
// [R18] Software restarts after reset and around stop
// [R19] Carry-driven advance, gated overflow reaches reset
module rcw_watchdog #(
    parameter logic [7:0] VECTOR_LOW = 8'h00
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Slow oscillator and test-voltage detectors
    input wire logic internal_slow_clock,
    input wire logic vtst_irq_pin,
    input wire logic vtst_rst_pin,
    // Core status, same clock
    input wire logic stop_mode,
    input wire logic monitor_mode,
    input wire logic break_active,
    input wire logic stop_instr,
    input wire logic reset_vector_fetch,
    input wire logic internal_reset_req,
    // Reset outputs
    output logic watchdog_reset,
    output logic illegal_opcode_reset,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    // System event line
    output logic irq
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [rcw_pkg::ADDR_W-1:0] idx_addr(input logic [15:0] idx);
        idx_addr = {idx, 2'b00};
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] pins_sync;
    logic slow_prev_reg;

    rcw_sync #(
        .W(3)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({vtst_rst_pin, vtst_irq_pin, internal_slow_clock}),
        .q(pins_sync)
    );

    wire logic slow_q = pins_sync[0];
    wire logic tst_irq = pins_sync[1];
    wire logic tst_rst = pins_sync[2];
    wire logic slow_rise = slow_q & ~slow_prev_reg; // [R2]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_prev_reg <= 1'b0;
        end else begin
            slow_prev_reg <= slow_q;
        end
    end

    // ****************************************
    // APB decode
    // ****************************************
    logic [7:0] config_reg;
    logic [rcw_pkg::CAUSE_W-1:0] cause_reg;
    logic [rcw_pkg::CAUSE_W-1:0] mask_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    wire logic hit_clear = paddr == idx_addr(rcw_pkg::CLEAR_IDX);
    wire logic hit_cfg = paddr == idx_addr(rcw_pkg::CONFIG_IDX);
    wire logic hit_cause = paddr == idx_addr(rcw_pkg::CAUSE_IDX);
    wire logic hit_mask = paddr == idx_addr(rcw_pkg::MASK_IDX);
    wire logic mapped = hit_clear | hit_cfg | hit_cause | hit_mask;
    wire logic setup = psel & ~penable;
    wire logic wr_fire = psel & penable & pready_reg & pwrite & mapped;
    wire logic service = wr_fire & hit_clear; // [R5]
    wire logic [31:0] rd_mux = hit_clear ? {24'h00_0000, VECTOR_LOW} : // [R6]
                               hit_cfg ? {24'h00_0000, config_reg} :
                               hit_cause ? {30'h0000_0000, cause_reg} :
                               hit_mask ? {30'h0000_0000, mask_reg} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
            prdata_reg <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // Configuration
    // ****************************************
    wire logic cfg_dis = config_reg[rcw_pkg::CFG_DIS_BIT];
    wire logic cfg_stop_en = config_reg[rcw_pkg::CFG_STOP_EN_BIT];
    wire logic cfg_rate = config_reg[rcw_pkg::CFG_RATE_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= rcw_pkg::CFG_RESET; // [R3]
        end else if (wr_fire & hit_cfg) begin
            config_reg <= pwdata[7:0];
        end
    end

    // ****************************************
    // Power-up prescaler clear
    // ****************************************
    logic [11:0] por_cnt_reg;
    logic por_done_reg;
    logic por_clr_reg;

    wire logic por_last = slow_rise & ~por_done_reg & (por_cnt_reg == rcw_pkg::POR_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt_reg <= 12'h000;
            por_done_reg <= 1'b0;
            por_clr_reg <= 1'b0;
        end else begin
            if (slow_rise & ~por_done_reg) begin
                por_cnt_reg <= por_cnt_reg + 12'h001;
            end
            por_done_reg <= por_done_reg | por_last;
            por_clr_reg <= por_last; // [R8]
        end
    end

    // ****************************************
    // Counter chain
    // ****************************************
    rcw_pkg::rcw_state_t state_reg;
    rcw_pkg::rcw_state_t state_next;
    logic [rcw_pkg::PRE_W-1:0] pre_cnt;
    logic [rcw_pkg::TMO_W-1:0] tmo_cnt;
    logic ovf;

    wire logic in_hold = state_reg == rcw_pkg::RCW_HOLD;
    // Wait mode is deliberately not an input: the chain keeps counting there
    wire logic chain_tick = slow_rise & ~stop_mode; // [R14] [R15]
    wire logic chain_clr_all = internal_reset_req | in_hold; // [R9]
    wire logic chain_clr_pre = stop_mode | reset_vector_fetch | por_clr_reg; // [R10] [R15]

    rcw_chain u_chain (
        .clk(pclk),
        .rst_n(presetn),
        .tick(chain_tick),
        .clr_all(chain_clr_all),
        .clr_pre(chain_clr_pre),
        .clr_service(service),
        .rate_sel(cfg_rate),
        .pre_cnt(pre_cnt),
        .tmo_cnt(tmo_cnt),
        .ovf(ovf)
    );

    // ****************************************
    // Overflow gating and reset hold
    // ****************************************
    logic [rcw_pkg::HOLD_W-1:0] hold_cnt_reg;

    wire logic mon_block = monitor_mode & (tst_irq | tst_rst); // [R13]
    wire logic brk_block = break_active & tst_rst; // [R17]
    wire logic wd_fire = ovf & ~cfg_dis & ~mon_block & ~brk_block; // [R11] [R19]
    wire logic wd_event = wd_fire & (state_reg == rcw_pkg::RCW_RUN); // [R4]
    wire logic hold_end = in_hold & slow_rise & (hold_cnt_reg == rcw_pkg::HOLD_LAST);
    wire logic ill_event = stop_instr & ~cfg_stop_en; // [R16]

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            rcw_pkg::RCW_RUN: begin
                if (wd_event) begin
                    state_next = rcw_pkg::RCW_HOLD;
                end
            end
            rcw_pkg::RCW_HOLD: begin
                if (hold_end) begin
                    state_next = rcw_pkg::RCW_RUN; // [R7]
                end
            end
            default: begin
                state_next = rcw_pkg::RCW_RUN;
            end
        endcase
    end

    wire logic hold_next = state_next == rcw_pkg::RCW_HOLD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= rcw_pkg::RCW_RUN;
            hold_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (!in_hold) begin
                hold_cnt_reg <= '0;
            end else if (slow_rise) begin
                hold_cnt_reg <= hold_cnt_reg + 5'h01;
            end
        end
    end

    // ****************************************
    // Cause, mask and outputs
    // ****************************************
    wire logic [rcw_pkg::CAUSE_W-1:0] cause_set = {ill_event, wd_event};
    wire logic [rcw_pkg::CAUSE_W-1:0] cause_w1c =
        (wr_fire & hit_cause) ? pwdata[rcw_pkg::CAUSE_W-1:0] : '0;
    // Set wins over a same-cycle clear
    wire logic [rcw_pkg::CAUSE_W-1:0] cause_next = (cause_reg & ~cause_w1c) | cause_set; // [R7]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_reg <= rcw_pkg::CAUSE_RESET;
            mask_reg <= rcw_pkg::MASK_RESET;
            irq <= 1'b0;
            watchdog_reset <= 1'b0;
            illegal_opcode_reset <= 1'b0;
            rst_pin_out <= 1'b1;
            rst_pin_oe <= 1'b0;
        end else begin
            cause_reg <= cause_next;
            if (wr_fire & hit_mask) begin
                mask_reg <= pwdata[rcw_pkg::CAUSE_W-1:0];
            end
            // Event line toward the system, never the processor's request input
            irq <= |(cause_next & mask_reg); // [R12]
            watchdog_reset <= hold_next; // [R4]
            illegal_opcode_reset <= ill_event; // [R16]
            rst_pin_out <= ~hold_next;
            rst_pin_oe <= hold_next; // [R7]
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [5:0] hold_ticks_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ticks_reg <= 6'h00;
        end else if (!in_hold) begin
            hold_ticks_reg <= 6'h00;
        end else if (slow_rise) begin
            hold_ticks_reg <= hold_ticks_reg + 6'h01;
        end
    end

    service_clear_a: assert property ( // [R5]
        service & ~internal_reset_req & ~in_hold |=> tmo_cnt == '0 &&
            pre_cnt[rcw_pkg::PRE_W-1:rcw_pkg::SERVICE_LOW] == '0)
        else $error("service write did not clear counters");

    clear_read_a: assert property ( // [R6]
        setup & ~pwrite & hit_clear |=> pready && prdata == {24'h00_0000, VECTOR_LOW}
            && ($stable(tmo_cnt) || $past(u_chain.carry) || $past(chain_clr_all)))
        else $error("clear port read wrong or disturbed counter");

    overflow_rate_a: assert property ( // [R3]
        ovf |-> tmo_cnt == (cfg_rate ? 6'h02 : 6'h00))
        else $error("overflow at wrong timeout count");

    timeout_reset_a: assert property ( // [R4]
        wd_event |=> watchdog_reset && rst_pin_oe && !rst_pin_out && cause_reg[0])
        else $error("timeout did not raise reset");

    disable_block_a: assert property ( // [R11]
        !watchdog_reset && cfg_dis |=> !watchdog_reset)
        else $error("disabled watchdog raised reset");

    monitor_block_a: assert property ( // [R13]
        !watchdog_reset && mon_block |=> !watchdog_reset)
        else $error("monitor mode did not block reset");

    break_block_a: assert property ( // [R17]
        !watchdog_reset && break_active && tst_rst |=> !watchdog_reset)
        else $error("break with test voltage did not block reset");

    hold_length_a: assert property ( // [R7]
        $fell(rst_pin_oe) |-> hold_ticks_reg == 6'h20)
        else $error("reset pin not held for 32 slow ticks");

    internal_clear_a: assert property ( // [R9]
        internal_reset_req |=> pre_cnt == '0 && tmo_cnt == '0)
        else $error("internal reset did not clear counters");

    prescaler_clear_a: assert property ( // [R10]
        reset_vector_fetch || stop_mode || por_clr_reg |=> pre_cnt == '0)
        else $error("prescaler not cleared");

    stop_freeze_a: assert property ( // [R15]
        stop_mode && !internal_reset_req && !in_hold && !service |=> $stable(tmo_cnt))
        else $error("timeout counter moved in stop mode");

    illegal_stop_a: assert property ( // [R16]
        stop_instr && !cfg_stop_en |=> illegal_opcode_reset ##1 !illegal_opcode_reset[*1])
        else $error("disabled stop did not give illegal opcode reset");

    cov_timeout_c: cover property (wd_event ##[1:1000] $fell(rst_pin_oe));
    cov_service_c: cover property (service ##1 tmo_cnt == '0);
    cov_illegal_c: cover property (illegal_opcode_reset ##1 irq);

endmodule // rcw_watchdog

// ==== sim/runaway_code_watchdog_tb.sv ====
`timescale 1ns/100ps

module runaway_code_watchdog_tb;
    // ****************************************
    // Clock, stimulus and design
    // ****************************************
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [rcw_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr;
    logic internal_slow_clock = 0, div = 0;
    logic stop_instr = 0, reset_vector_fetch = 0, internal_reset_req = 0;
    logic stop_mode = 0, monitor_mode = 0, break_active = 0, vtst_irq_pin = 0, vtst_rst_pin = 0;
    logic watchdog_reset, illegal_opcode_reset, rst_pin_out, rst_pin_oe, irq;
    int failures = 0, n_compared = 0, seed = 19131, tick_count = 0;
    int t0, elapsed;
    logic [31:0] rd;
    logic er, wd_seen;
    // Shortest possible timeout once the chain is cleared
    localparam int SHORT_TICKS = 2 ** 13 - 2 ** 4;
    // Arbitrary reset-vector byte, so the clear-port read is told apart from zero
    localparam logic [7:0] VEC_LOW = 8'h5a;
    // Power-up clear lands 4096 ticks after release; wait a little beyond it
    localparam int POR_WAIT = 4096 + 16;

    initial forever #50 pclk = ~pclk;

    // Slow oscillator at a quarter of pclk, the fastest the syncs accept
    always @(posedge pclk) begin
        div <= ~div;
        if (div) begin
            internal_slow_clock <= ~internal_slow_clock;
            if (!internal_slow_clock) tick_count <= tick_count + 1;
        end
    end

    always @(negedge pclk) if (watchdog_reset === 1'b1) wd_seen = 1'b1;

    rcw_watchdog #(.VECTOR_LOW(VEC_LOW)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .internal_slow_clock(internal_slow_clock),
        .vtst_irq_pin(vtst_irq_pin), .vtst_rst_pin(vtst_rst_pin), .stop_mode(stop_mode),
        .monitor_mode(monitor_mode), .break_active(break_active), .stop_instr(stop_instr),
        .reset_vector_fetch(reset_vector_fetch),
        .internal_reset_req(internal_reset_req),
        .watchdog_reset(watchdog_reset), .illegal_opcode_reset(illegal_opcode_reset),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .irq(irq)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic test_done();
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h0000_0001, {31'h0, k < 50});
    endtask

    task automatic pulse(input bit stop_sel);
        @(posedge pclk);
        if (stop_sel) begin
            stop_instr <= 1'b1;
        end else begin
            internal_reset_req <= 1'b1;
        end
        @(posedge pclk);
        stop_instr <= 1'b0;
        internal_reset_req <= 1'b0;
    endtask

    task automatic wait_ticks(input int n);
        t0 = tick_count;
        while (tick_count - t0 < n) @(negedge pclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, rcw_pkg::CONFIG_IDX, 0, rd, er);
        chk("config reset", {24'h0, rcw_pkg::CFG_RESET}, rd);
        apb(0, rcw_pkg::CAUSE_IDX, 0, rd, er);
        chk("cause reset", {30'h0, rcw_pkg::CAUSE_RESET}, rd);
        apb(0, rcw_pkg::MASK_IDX, 0, rd, er);
        chk("mask reset", {30'h0, rcw_pkg::MASK_RESET}, rd);
        apb(0, rcw_pkg::CLEAR_IDX, 0, rd, er);
        chk("clear port read", {24'h00_0000, VEC_LOW}, rd);
        chk("clear port err", 32'h0000_0000, {31'h0, er});
        apb(1, 16'h1234, 32'hffff_ffff, rd, er);
        chk("unmapped write err", 32'h0000_0001, {31'h0, er});
        apb(0, 16'h1234, 0, rd, er);
        chk("unmapped read", 32'h0000_0001, {rd[30:0], er});
        repeat (4) begin
            pwdata <= pwdata;
            t0 = $random(seed) & 32'h0000_0083;
            apb(1, rcw_pkg::CONFIG_IDX, t0, rd, er);
            apb(0, rcw_pkg::CONFIG_IDX, 0, rd, er);
            chk("config readback", t0, rd & 32'h0000_0083);
        end
        // Stop instruction while stop is disabled
        apb(1, rcw_pkg::CONFIG_IDX, 32'h0000_0000, rd, er);
        pulse(1'b1);
        @(negedge pclk);
        chk("illegal reset", 32'h0000_0001, {31'h0, illegal_opcode_reset});
        @(negedge pclk);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        apb(0, rcw_pkg::CAUSE_IDX, 0, rd, er);
        chk("illegal cause", 32'h0000_0002, rd);
        apb(1, rcw_pkg::CAUSE_IDX, 32'h0000_0002, rd, er);
        apb(0, rcw_pkg::CAUSE_IDX, 0, rd, er);
        chk("cause cleared", 32'h0000_0000, rd);
        apb(1, rcw_pkg::CONFIG_IDX, 32'h0000_0002, rd, er);
        wd_seen = 1'b0;
        pulse(1'b1);
        repeat (3) @(negedge pclk);
        chk("stop allowed", 32'h0000_0000, {31'h0, illegal_opcode_reset});
        // Disabled watchdog with the short rate must never reset
        apb(1, rcw_pkg::CONFIG_IDX, 32'h0000_0083, rd, er);
        // A later power-up clear would push the overflow out of the window
        while (tick_count < POR_WAIT) @(negedge pclk);
        @(posedge pclk);
        monitor_mode <= 1'b1;
        vtst_rst_pin <= 1'b1;
        pulse(1'b0);
        wait_ticks(SHORT_TICKS + 200);
        chk("disabled no reset", 32'h0000_0000, {31'h0, wd_seen});
        // Enabled short timeout, serviced once at a random moment
        // Break with voltage on the request pin only must not block
        @(posedge pclk);
        monitor_mode <= 1'b0;
        vtst_rst_pin <= 1'b0;
        break_active <= 1'b1;
        vtst_irq_pin <= 1'b1;
        apb(1, rcw_pkg::MASK_IDX, 32'h0000_0001, rd, er);
        apb(1, rcw_pkg::CONFIG_IDX, 32'h0000_0082, rd, er);
        pulse(1'b0);
        reset_vector_fetch <= 1'b1;
        @(posedge pclk);
        reset_vector_fetch <= 1'b0;
        wait_ticks(500 + ($random(seed) & 511));
        apb(1, rcw_pkg::CLEAR_IDX, $random(seed), rd, er);
        chk("no early reset", 32'h0000_0000, {31'h0, wd_seen});
        // Stop wipes the whole prescaler, so a full period starts at release
        @(posedge pclk);
        stop_mode <= 1'b1;
        wait_ticks(200);
        @(posedge pclk);
        stop_mode <= 1'b0;
        t0 = tick_count;
        while (watchdog_reset !== 1'b1 && tick_count - t0 < SHORT_TICKS + 200) begin
            @(negedge pclk);
        end
        elapsed = tick_count - t0;
        chk("timeout window", 32'h0000_0001,
            {31'h0, elapsed >= SHORT_TICKS - 16 && elapsed <= SHORT_TICKS + 24});
        chk("pin driven", 32'h0000_0002, {30'h0, rst_pin_oe, rst_pin_out});
        t0 = tick_count;
        while (rst_pin_oe === 1'b1 && tick_count - t0 < 40) @(negedge pclk);
        elapsed = tick_count - t0;
        chk("hold length", 32'h0000_0001, {31'h0, elapsed >= 31 && elapsed <= 33});
        chk("pin released", 32'h0000_0001, {30'h0, rst_pin_oe, rst_pin_out});
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        apb(0, rcw_pkg::CAUSE_IDX, 0, rd, er);
        chk("watchdog cause", 32'h0000_0001, rd & 32'h0000_0001);
        apb(1, rcw_pkg::CAUSE_IDX, 32'h0000_0001, rd, er);
        @(negedge pclk);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        test_done();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        test_done();
    end
endmodule // runaway_code_watchdog_tb
